/* File: common/pulse_delay_defs.svh */
/*
 * Timing constants for the delay generator host controller.
 * Assumes a 50 MHz system clock; the including file supplies the arithmetic context.
 */
`ifndef PULSE_DELAY_DEFS_SVH
`define PULSE_DELAY_DEFS_SVH

// -------------------------------------------------------------------------
// Clock and timing
// -------------------------------------------------------------------------
`define CLK_PERIOD_NS        20
`define THRESHOLD_SETTLE_NS  30
`define THRESHOLD_SETTLE_CYC ((`THRESHOLD_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RAMP_SETTLE_NS       100
`define RAMP_SETTLE_CYC      ((`RAMP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_PROP_DELAY_NS    20
`define MIN_PROP_DELAY_CYC   ((`MIN_PROP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FULL_SCALE_NS        100
`define CODE_STEPS           256
`define RESET_WIDTH_CYC      2
`define TRIGGER_WIDTH_CYC    2

`endif

/* File: common/pulse_delay_pkg.sv */
/*
 * Types shared by the delay generator host controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pulse_delay_pkg;

    // -------------------------------------------------------------------------
    // Sequencer states
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_SETTLE,
        ST_FIRE,
        ST_WAIT,
        ST_RESET,
        ST_RECOVER
    } seqState_t;

    typedef logic [7:0] delayCode_t;

endpackage

/* File: hdl/delay_calc.sv */
/*
 * Converts a delay code into a cycle count: minimum delay plus code/256 of
 * the full-scale range, rounded up.
 * Assumes a registered, same-clock code input.
 */
`timescale 1ns/1ps
`include "pulse_delay_defs.svh"

module delay_calc
    import pulse_delay_pkg::*;
#(
    parameter int FULL_SCALE_NS = `FULL_SCALE_NS
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        clockEnable,
    input  wire delayCode_t  code,
    output logic      [15:0] totalCycles
);

    // -------------------------------------------------------------------------
    // Arithmetic
    // -------------------------------------------------------------------------
    localparam int STEP_DEN = `CODE_STEPS * `CLK_PERIOD_NS;

    // Rounds up so the external reset never lands before the output edge.
    function automatic logic [15:0] cyclesFor(input delayCode_t c);
        logic [31:0] num;
        num = 32'(c) * 32'(FULL_SCALE_NS) + 32'(STEP_DEN - 1);
        return 16'(num / 32'(STEP_DEN)) + 16'(`MIN_PROP_DELAY_CYC);
    endfunction

    logic [15:0] total_d;
    logic [15:0] total_q;

    // Next value of the cycle count.
    always_comb begin
        total_d = cyclesFor(code);
    end

    // Registered so the top sees a clean value.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            total_q <= 16'h0000;
        end else if (clockEnable) begin
            total_q <= total_d;
        end
    end

    assign totalCycles = total_q;

    zeroCodeMin_a: assert property (@(posedge clock) disable iff (!nrst)
        (clockEnable && code == 8'h00) |=> total_q == 16'(`MIN_PROP_DELAY_CYC))
        else $error("zero code does not give minimum delay");

endmodule

/* File: hdl/pulse_delay_host.sv */
/*
 * Host controller that drives the programmable delay generator pins: code,
 * hold control, trigger and external reset, and watches its output.
 * Assumes the device output pin is asynchronous; it is synchronised here.
 */
//Contract
//- Wait 30 ns after hold before trigger.
//- Wait ramp settling after reset release.
//- Output fed to reset gives narrow pulse.
//- External reset no sooner than total delay.
//- Wider pulse by delayed or external reset.
`timescale 1ns/1ps
`include "pulse_delay_defs.svh"

module pulse_delay_host
    import pulse_delay_pkg::*;
#(
    parameter int FULL_SCALE_NS = `FULL_SCALE_NS,
    parameter int PULSE_EXTRA   = 0
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        clockEnable,
    input  wire logic        startReq,
    input  wire delayCode_t  startCode,
    input  wire logic        selfReset,
    input  wire logic        devOut,
    output logic             busy,
    output logic             done,
    output logic             outSeen,
    output delayCode_t       delayCodeOut,
    output logic             holdCtl,
    output logic             trigger,
    output logic             resetCtl
);

    // -------------------------------------------------------------------------
    // Output pin synchroniser
    // -------------------------------------------------------------------------
    logic syncA_q;
    logic syncB_q;

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    seqState_t  state_q, state_d;
    logic [15:0] cnt_q, cnt_d;
    delayCode_t code_q, code_d;
    logic        hold_q, hold_d;
    logic        trig_q, trig_d;
    logic        rst_q, rst_d;
    logic        self_q, self_d;
    logic        seen_q, seen_d;
    logic        done_q, done_d;
    logic        busy_q, busy_d;
    logic [15:0] totalCycles;

    delay_calc #(
        .FULL_SCALE_NS (FULL_SCALE_NS)
    ) u_calc (
        .clock         (clock),
        .nrst          (nrst),
        .clockEnable   (clockEnable),
        .code          (code_q),
        .totalCycles   (totalCycles)
    );

    // Next values of the sequencer.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        code_d  = code_q;
        hold_d  = hold_q;
        trig_d  = trig_q;
        rst_d   = rst_q;
        self_d  = self_q;
        seen_d  = seen_q;
        done_d  = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (startReq) begin
                    code_d  = startCode;
                    self_d  = selfReset;
                    hold_d  = 1'b0;
                    seen_d  = 1'b0;
                    rst_d   = 1'b0;
                    // A device reset still held from power-up needs ramp settling first.
                    cnt_d   = rst_q ? 16'(`RAMP_SETTLE_CYC) : 16'(`THRESHOLD_SETTLE_CYC);
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                hold_d  = 1'b1;
                state_d = ST_SETTLE;
            end
            ST_SETTLE: begin
                // Triggering earlier would be accepted but inaccurate.
                if (cnt_q <= 16'h0001) begin
                    trig_d  = 1'b1;
                    cnt_d   = 16'(`TRIGGER_WIDTH_CYC);
                    state_d = ST_FIRE;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            ST_FIRE: begin
                if (cnt_q <= 16'h0001) begin
                    trig_d  = 1'b0;
                    cnt_d   = totalCycles + 16'(PULSE_EXTRA);
                    state_d = ST_WAIT;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            ST_WAIT: begin
                // Both modes wait out the full delay, so a looped reset has fired first.
                if (cnt_q <= 16'h0001) begin
                    rst_d   = !self_q;
                    cnt_d   = 16'(`RESET_WIDTH_CYC);
                    state_d = ST_RESET;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            ST_RESET: begin
                if (cnt_q <= 16'h0001) begin
                    rst_d   = 1'b0;
                    cnt_d   = 16'(`RAMP_SETTLE_CYC);
                    state_d = ST_RECOVER;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            ST_RECOVER: begin
                if (cnt_q <= 16'h0001) begin
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // The device output seen at any time is recorded for the caller.
        if (syncB_q) begin
            seen_d = 1'b1;
        end
        busy_d = (state_d != ST_IDLE);
    end

    // Registers of the sequencer and synchroniser.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            cnt_q   <= 16'h0000;
            code_q  <= 8'h00;
            hold_q  <= 1'b1;
            trig_q  <= 1'b0;
            rst_q   <= 1'b1;
            self_q  <= 1'b0;
            seen_q  <= 1'b0;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
            syncA_q <= 1'b0;
            syncB_q <= 1'b0;
        end else if (clockEnable) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            code_q  <= code_d;
            hold_q  <= hold_d;
            trig_q  <= trig_d;
            rst_q   <= rst_d;
            self_q  <= self_d;
            seen_q  <= seen_d;
            done_q  <= done_d;
            busy_q  <= busy_d;
            syncA_q <= devOut;
            syncB_q <= syncA_q;
        end
    end

    assign busy         = busy_q;
    assign done         = done_q;
    assign outSeen      = seen_q;
    assign delayCodeOut = code_q;
    assign holdCtl      = hold_q;
    assign trigger      = trig_q;
    assign resetCtl     = rst_q;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    holdBeforeTrig_a: assert property (@(posedge clock) disable iff (!nrst)
        $rose(trig_q) |-> $past(hold_q, 2))
        else $error("trigger without settled hold");
    codeStable_a: assert property (@(posedge clock) disable iff (!nrst)
        (hold_q && $past(hold_q)) |-> $stable(code_q))
        else $error("code changed while held");
    resetNoTrig_a: assert property (@(posedge clock) disable iff (!nrst)
        rst_q |-> !trig_q)
        else $error("trigger while reset high");
    settleAfterReset_a: assert property (@(posedge clock) disable iff (!nrst)
        $fell(rst_q) |-> !trig_q [*5])
        else $error("trigger inside ramp settling");
    resetLate_a: assert property (@(posedge clock) disable iff (!nrst)
        $rose(trig_q) |-> !rst_q [*3])
        else $error("reset too soon after trigger");
    doneOnly_a: assert property (@(posedge clock) disable iff (!nrst)
        done_q |-> state_q == ST_IDLE)
        else $error("done outside idle");
    transp_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == ST_IDLE && startReq && clockEnable) |=> !hold_q)
        else $error("hold not opened for load");
    selfNoRst_a: assert property (@(posedge clock) disable iff (!nrst)
        (self_q && state_q == ST_RESET) |-> !rst_q)
        else $error("reset driven in self reset mode");

    fire_c: cover property (@(posedge clock) disable iff (!nrst) $rose(trig_q));
    ext_c: cover property (@(posedge clock) disable iff (!nrst) $rose(rst_q));
    done_c: cover property (@(posedge clock) disable iff (!nrst) done_q);

endmodule

/* File: tb/delay_device_model.sv */
/*
 * Behavioural model of the programmable delay generator.
 * Assumes the host drives the code, hold, trigger and reset pins.
 */
`timescale 1ns/1ps

module delay_device_model #(
    parameter int FULL_SCALE_NS = 100,
    parameter int MIN_PROP_NS   = 20,
    parameter int RESET_PROP_NS = 5
) (
    input  wire logic [7:0] codePins,
    input  wire logic       holdPin,
    input  wire logic       trigPin,
    input  wire logic       resetPin,
    input  wire logic       selfLoop,
    output logic            devOut
);
    // ---------------------------------------------------------------------
    // Code latch and ramp
    // ---------------------------------------------------------------------
    logic [7:0] heldCode;
    logic       resetEff;
    int         cycleId = 0;

    // The loop option models the output wired straight back to reset.
    assign resetEff = resetPin | (selfLoop & devOut);

    // Transparent while hold is low, frozen while it is high.
    always_latch begin
        if (!holdPin) heldCode <= codePins;
    end

    initial devOut = 1'b0;

    // A stale cycle id cancels a ramp that a reset cut short.
    task automatic launch(input int id, input real dly);
        #(dly);
        if (id == cycleId && !resetEff) devOut = 1'b1;
    endtask

    // Triggers are taken at any code, but never while reset is high.
    always @(posedge trigPin) begin
        if (!resetEff) begin
            cycleId++;
            fork
                launch(cycleId, MIN_PROP_NS + heldCode * FULL_SCALE_NS / 256.0);
            join_none
        end
    end

    // Reset discharges the ramp and drops the output.
    always @(posedge resetEff) begin
        cycleId++;
        #(RESET_PROP_NS);
        devOut = 1'b0;
    end
endmodule

/* File: tb/tb_pulse_delay_host.sv */
/*
 * Self-checking bench for the delay generator host controller.
 * Assumes the device model sits on the host's pins.
 */
`timescale 1ns/1ps
`include "pulse_delay_defs.svh"
`define CHECK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module tb_pulse_delay_host
    import pulse_delay_pkg::*;
;
    // ---------------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------------
    logic       clock = 1'b0;
    logic       nrst = 1'b0;
    logic       clockEnable = 1'b1;
    logic       startReq = 1'b0;
    delayCode_t startCode = 8'h00;
    logic       selfReset = 1'b0;
    logic       busy, done, outSeen, holdCtl, trigger, resetCtl, devOut;
    delayCode_t delayCodeOut;
    int         n_fail = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    int         pulses = 0;

    pulse_delay_host pulse_delay_host_inst (
        .clock(clock), .nrst(nrst), .clockEnable(clockEnable), .startReq(startReq),
        .startCode(startCode), .selfReset(selfReset), .busy(busy), .done(done),
        .outSeen(outSeen), .delayCodeOut(delayCodeOut), .holdCtl(holdCtl),
        .trigger(trigger), .resetCtl(resetCtl), .devOut(devOut)
    );

    delay_device_model delay_device_model_inst (
        .codePins(delayCodeOut), .holdPin(holdCtl), .trigPin(trigger),
        .resetPin(resetCtl), .selfLoop(selfReset), .devOut(devOut)
    );

    initial forever #10 clock = ~clock;

    always @(posedge devOut) pulses++;

    // A hung sequence counts as a mismatch rather than running forever.
    always @(posedge clock) begin
        cycles++;
        if (cycles >= 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ---------------------------------------------------------------------
    // One full delay cycle at a given code and reset mode
    // ---------------------------------------------------------------------
    task automatic run_cycle(input delayCode_t code, input logic loopMode);
        int c;
        int total;
        int p0;
        logic rstSeen;
        total = (code * `FULL_SCALE_NS + 5119) / 5120 + 1;
        p0 = pulses;
        rstSeen = 1'b0;
        @(posedge clock);
        startCode <= code;
        selfReset <= loopMode;
        startReq <= 1'b1;
        c = 0;
        while (holdCtl !== 1'b0 && c < 20) begin @(posedge clock); #1; c++; end
        startReq <= 1'b0;
        `CHECK(busy, 1'b1);
        `CHECK(delayCodeOut, code);
        `CHECK(outSeen, 1'b0);
        c = 0;
        while (holdCtl !== 1'b1 && c < 20) begin @(posedge clock); #1; c++; end
        c = 0;
        while (trigger !== 1'b1 && c < 20) begin @(posedge clock); #1; c++; end
        `CHECK(c * `CLK_PERIOD_NS >= `THRESHOLD_SETTLE_NS, 1'b1);
        `CHECK(holdCtl, 1'b1);
        c = 0;
        while (!loopMode && resetCtl !== 1'b1 && c < 50) begin
            @(posedge clock); #1; c++;
        end
        if (!loopMode) begin
            `CHECK(c, total + 2);
            `CHECK(devOut, 1'b1);
            c = 0;
            while (resetCtl === 1'b1 && c < 20) begin @(posedge clock); #1; c++; end
            `CHECK(c, `RESET_WIDTH_CYC);
            `CHECK(devOut, 1'b0);
            c = 0;
            while (done !== 1'b1 && c < 50) begin @(posedge clock); #1; c++; end
            `CHECK(c >= `RAMP_SETTLE_CYC, 1'b1);
            `CHECK(outSeen, 1'b1);
        end else begin
            // Host must leave reset to the looped output in this mode.
            while (done !== 1'b1 && c < 100) begin
                rstSeen |= resetCtl;
                @(posedge clock); #1; c++;
            end
            `CHECK(rstSeen, 1'b0);
            `CHECK(devOut, 1'b0);
        end
        `CHECK(done, 1'b1);
        `CHECK(pulses, p0 + 1);
        @(posedge clock); #1;
        `CHECK(done, 1'b0);
    endtask

    // A request made while the enable is low must leave the sequencer idle.
    task automatic freeze_idle();
        @(posedge clock);
        clockEnable <= 1'b0;
        startReq <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        `CHECK({busy, holdCtl}, 2'b01);
        @(posedge clock);
        startReq <= 1'b0;
        clockEnable <= 1'b1;
        @(posedge clock);
        #1;
        `CHECK(busy, 1'b0);
    endtask

    // ---------------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        #1;
        `CHECK({holdCtl, resetCtl, trigger, done}, 4'b1100);
        `CHECK(delayCodeOut, 8'h00);
        `CHECK(busy, 1'b0);
        @(posedge clock);
        nrst <= 1'b1;
        run_cycle(8'h00, 1'b0);
        freeze_idle();
        run_cycle(8'hFF, 1'b0);
        run_cycle(8'h01, 1'b0);
        run_cycle(8'h80, 1'b0);
        run_cycle(8'h80, 1'b1);
        run_cycle(8'hFF, 1'b1);
        wrap_up();
    end
endmodule
